// ==== hw/spi_baud_gen.sv ====
// Serial bit rate generator with an AXI4-Lite register slave.
// Assumes one bus clock, a synchronous active-low reset and a master
// that keeps the AXI4-Lite handshakes.
`include "spi_baud_defs.svh"

module spi_baud_gen (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [31:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output      logic        S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output      logic        S_AXI_WREADY,
	output      logic [1:0]  S_AXI_BRESP,
	output      logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [31:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output      logic        S_AXI_ARREADY,
	output      logic [31:0] S_AXI_RDATA,
	output      logic [1:0]  S_AXI_RRESP,
	output      logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output      logic        BIT_CLK,
	output      logic        BIT_RATE_TICK,
	output      logic        MASTER_ACTIVE
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [`DIV_CFG_W-1:0]       div_cfg_q;
	spi_baud_pkg::role_t         role_q;
	logic                        awready_q;
	logic                        wready_q;
	logic                        bvalid_q;
	spi_baud_pkg::axi_resp_t     bresp_q;
	logic                        arready_q;
	logic                        rvalid_q;
	spi_baud_pkg::axi_resp_t     rresp_q;
	logic [31:0]                 rdata_q;
	logic                        bit_clk_q;
	logic                        rate_tick_q;
	logic                        master_q;
	logic                        wr_take;
	logic                        rd_take;
	logic                        wr_hit_cfg;
	logic                        wr_hit_role;
	logic                        wr_mapped;
	logic                        rd_mapped;
	logic [31:0]                 rd_word;
	logic [31:0]                 status_word;
	spi_baud_pkg::prescale_sel_t prescale_select;
	spi_baud_pkg::rate_sel_t     rate_divider_select;
	logic [`RATE_CW-1:0]         rate_half;

	div_stage_if #(.W(`PRE_CW))  pre_if ();
	div_stage_if #(.W(`RATE_CW)) rate_if ();

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	// Address and data are taken together in one cycle, once both wait
	assign wr_take = S_AXI_AWVALID && S_AXI_WVALID && !awready_q
		&& !bvalid_q;
	assign wr_hit_cfg  = (S_AXI_AWADDR == `OFS_DIV_CFG);
	assign wr_hit_role = (S_AXI_AWADDR == `OFS_ROLE);
	assign wr_mapped   = wr_hit_cfg || wr_hit_role
		|| (S_AXI_AWADDR == `OFS_STATUS);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
		end else begin
			awready_q <= wr_take;
			wready_q  <= wr_take;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (wr_take) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_q && S_AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Accepted whatever the divider is doing; reserved bits stay clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			div_cfg_q <= `DIV_CFG_RST;
		end else if (wr_take && wr_hit_cfg && S_AXI_WSTRB[0]) begin
			div_cfg_q <= S_AXI_WDATA[`DIV_CFG_W-1:0] & `DIV_CFG_MASK;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			role_q <= spi_baud_pkg::role_t'(`ROLE_RST);
		end else if (wr_take && wr_hit_role && S_AXI_WSTRB[0]) begin
			role_q <= spi_baud_pkg::role_t'(S_AXI_WDATA[`ROLE_BIT]);
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	assign rd_take   = S_AXI_ARVALID && !arready_q && !rvalid_q;
	assign rd_mapped = (S_AXI_ARADDR == `OFS_DIV_CFG)
		|| (S_AXI_ARADDR == `OFS_ROLE)
		|| (S_AXI_ARADDR == `OFS_STATUS);

	always_comb begin
		status_word = '0;
		status_word[`STAT_CLK_BIT]    = bit_clk_q;
		status_word[`STAT_MASTER_BIT] = master_q;
		status_word[`STAT_PRE_MSB:`STAT_PRE_LSB]   = prescale_select;
		status_word[`STAT_RATE_MSB:`STAT_RATE_LSB] = rate_half;
	end

	always_comb begin
		rd_word = '0;
		if (S_AXI_ARADDR == `OFS_DIV_CFG) begin
			rd_word[`DIV_CFG_W-1:0] = div_cfg_q;
		end else if (S_AXI_ARADDR == `OFS_ROLE) begin
			rd_word[`ROLE_BIT] = role_q;
		end else if (S_AXI_ARADDR == `OFS_STATUS) begin
			rd_word = status_word;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			arready_q <= 1'b0;
		end else begin
			arready_q <= rd_take;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rvalid_q <= 1'b0;
			rresp_q  <= `RESP_OKAY;
			rdata_q  <= '0;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
			rdata_q  <= rd_word;
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Prescaler stage
	// ------------------------------------------------------------
	// Code n counts n plus one bus clocks per tick
	assign prescale_select = div_cfg_q[`PRESCALE_MSB:`PRESCALE_LSB];
	assign pre_if.clear    = !master_q;
	assign pre_if.en       = 1'b1;
	assign pre_if.terminal = prescale_select;

	div_stage #(.W(`PRE_CW)) u_prescale (
		.clk     (CLK),
		.rst_n   (RST_N),
		.port_if (pre_if)
	);

	// ------------------------------------------------------------
	// Rate divider stage
	// ------------------------------------------------------------
	// Half period is two to the code prescale ticks, so the full
	// period is two to the code plus one
	assign rate_divider_select = div_cfg_q[`RATE_MSB:`RATE_LSB];
	assign rate_half = (`RATE_ONE << rate_divider_select) - `RATE_ONE;
	assign rate_if.clear    = !master_q;
	assign rate_if.en       = pre_if.tick;
	assign rate_if.terminal = rate_half;

	div_stage #(.W(`RATE_CW)) u_rate (
		.clk     (CLK),
		.rst_n   (RST_N),
		.port_if (rate_if)
	);

	// ------------------------------------------------------------
	// Role
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			master_q <= 1'b0;
		end else begin
			master_q <= (role_q == spi_baud_pkg::ROLE_MASTER);
		end
	end

	// ------------------------------------------------------------
	// Bit clock
	// ------------------------------------------------------------
	// Two toggles per period: bus clock over prescale times rate
	always_ff @(posedge CLK) begin
		if (!RST_N || !master_q) begin
			bit_clk_q <= 1'b0;
		end else if (rate_if.tick) begin
			bit_clk_q <= !bit_clk_q;
		end
	end

	// One pulse per full bit period, on the falling toggle
	always_ff @(posedge CLK) begin
		if (!RST_N || !master_q) begin
			rate_tick_q <= 1'b0;
		end else begin
			rate_tick_q <= rate_if.tick && bit_clk_q;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = wready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RRESP   = rresp_q;
	assign S_AXI_RDATA   = rdata_q;
	assign BIT_CLK       = bit_clk_q;
	assign BIT_RATE_TICK = rate_tick_q;
	assign MASTER_ACTIVE = master_q;
endmodule : spi_baud_gen

// ==== hw/spi_baud_defs.svh ====
// Constants of the serial bit rate generator: offsets, fields, resets.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SPI_BAUD_DEFS_SVH
`define SPI_BAUD_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_DIV_CFG      32'h0000_0000
`define OFS_ROLE         32'h0000_0004
`define OFS_STATUS       32'h0000_0008

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PRESCALE_MSB     6
`define PRESCALE_LSB     4
`define RATE_MSB         2
`define RATE_LSB         0
`define DIV_CFG_W        8
`define DIV_CFG_MASK     8'h77
`define DIV_CFG_RST      8'h00
`define ROLE_BIT         0
`define ROLE_RST         1'b0
`define STAT_CLK_BIT     0
`define STAT_MASTER_BIT  1
`define STAT_PRE_LSB     4
`define STAT_PRE_MSB     6
`define STAT_RATE_LSB    8
`define STAT_RATE_MSB    14

// ------------------------------------------------------------
// Divider counter widths
// ------------------------------------------------------------
`define PRE_CW           3
`define RATE_CW          7
`define RATE_ONE         7'h01

// ------------------------------------------------------------
// Bus response codes
// ------------------------------------------------------------
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== hw/spi_baud_pkg.sv ====
// Types shared by the serial bit rate generator.
// Assumes compilation before every file that names it.
package spi_baud_pkg;
	typedef logic [2:0] prescale_sel_t;
	typedef logic [2:0] rate_sel_t;
	typedef logic [1:0] axi_resp_t;
	typedef enum logic {
		ROLE_SLAVE,
		ROLE_MASTER
	} role_t;
endpackage : spi_baud_pkg

// ==== hw/div_stage_if.sv ====
// Link between the generator and one of its divider stages.
// Assumes the stage and its controller share one clock.
interface div_stage_if #(parameter int W = 3);
	logic         clear;
	logic         en;
	logic [W-1:0] terminal;
	logic         tick;

	modport ctrl  (output clear, output en, output terminal, input tick);
	modport stage (input clear, input en, input terminal, output tick);
endinterface : div_stage_if

// ==== hw/div_stage.sv ====
// One divider stage: counts enable pulses and ticks on the terminal count.
// Assumes a synchronous active-low reset and a terminal that may change
// at any time.
module div_stage #(
	parameter int W = 3
) (
	input wire logic   clk,
	input wire logic   rst_n,
	div_stage_if.stage port_if
);
	logic [W-1:0] cnt_q;
	logic         tick_q;
	logic         wrap;

	// A lowered terminal never lets the count run past it
	assign wrap = (cnt_q >= port_if.terminal);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n || port_if.clear) begin
			cnt_q <= '0;
		end else if (port_if.en) begin
			if (wrap) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end

	// ------------------------------------------------------------
	// Tick
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n || port_if.clear) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= port_if.en && wrap;
		end
	end

	assign port_if.tick = tick_q;
endmodule : div_stage

// ==== bench/bit_clk_sink.sv ====
// Far-side model: a serial slave that times the bit clock it receives.
// Assumes the bit clock is a level sampled on the bus clock.
module bit_clk_sink (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        bit_clk,
	output      logic [31:0] period,
	output      logic [31:0] edges
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        bit_clk_q;
	logic [31:0] run_q;

	// ------------------------------------------------------------
	// Rising edge timing
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_clk_q <= 1'b0;
			run_q     <= 32'h0;
			period    <= 32'h0;
			edges     <= 32'h0;
		end else begin
			bit_clk_q <= bit_clk;
			run_q     <= run_q + 32'h1;
			if (bit_clk && !bit_clk_q) begin
				period <= run_q + 32'h1;
				run_q  <= 32'h0;
				edges  <= edges + 32'h1;
			end
		end
	end
endmodule : bit_clk_sink

// ==== bench/spi_baud_asserts.sv ====
// Checker: bus handshakes and bit clock of the rate generator.
// Assumes a bind to spi_baud_gen; sees only its ports.
module spi_baud_asserts (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        BIT_CLK,
	input wire logic        BIT_RATE_TICK,
	input wire logic        MASTER_ACTIVE
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [10:0] run_q;
	logic        prev_q;
	always_ff @(posedge CLK) begin
		prev_q <= BIT_CLK;
		if (!RST_N || !MASTER_ACTIVE || BIT_CLK != prev_q)
			run_q <= 11'h000;
		else
			run_q <= run_q + {10'h000, run_q != 11'h7FF};
	end
	sequence wr_take;
		S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
	endsequence
	sequence rd_take;
		S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
	endsequence
	AST_WR_ANSWER:
	assert property (wr_take |=> S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID)
		else $error("write not answered next cycle");
	AST_RD_ANSWER:
	assert property (rd_take |=> S_AXI_ARREADY && S_AXI_RVALID)
		else $error("read not answered next cycle");
	AST_R_HOLD:
	assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
		&& $stable(S_AXI_RDATA)) else $error("read answer dropped");
	AST_READY_PULSE:
	assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write ready held");
	AST_SLAVE_QUIET:
	assert property (!MASTER_ACTIVE [*2] |-> !BIT_CLK && !BIT_RATE_TICK)
		else $error("bit clock runs in slave role");
	AST_TICK_AFTER_HIGH:
	assert property (BIT_RATE_TICK |-> $past(BIT_CLK) || $past(BIT_CLK, 2))
		else $error("tick without bit clock high");
	AST_TICK_PULSE:
	assert property (BIT_RATE_TICK |=> !BIT_RATE_TICK)
		else $error("tick longer than one cycle");
	AST_HALF_BOUND:
	assert property (run_q < 11'h406)
		else $error("bit clock half period too long");
endmodule : spi_baud_asserts

bind spi_baud_gen spi_baud_asserts spi_baud_asserts_inst (.*);

// ==== bench/testbench.sv ====
// Testbench: register access and bit clock rates of the generator.
// Assumes the design files and the far-side model are compiled first.
`include "spi_baud_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic BIT_CLK, BIT_RATE_TICK, MASTER_ACTIVE;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
	logic [31:0] period, edges, rd_d;
	logic [3:0]  S_AXI_WSTRB;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rd_r, wr_b;
	int          error_cnt, check_count;

	spi_baud_gen spi_baud_gen_inst (.*);
	bit_clk_sink bit_clk_sink_inst (.clk(CLK), .rst_n(RST_N),
		.bit_clk(BIT_CLK), .period(period), .edges(edges));

	always #20 CLK = ~CLK;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic stuck(input int n);
		if (n > 20000) begin
			chk(32'h0, 32'h1);
			report_and_stop();
		end
	endtask : stuck

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
			if (S_AXI_BVALID) begin
				wr_b = S_AXI_BRESP;
				S_AXI_BREADY <= 1'b0;
			end
			stuck(n++);
			#1;
		end while (S_AXI_BREADY);
	endtask : wr

	task automatic rd(input logic [31:0] a);
		int n;
		n = 0;
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_RVALID) begin
				rd_d = S_AXI_RDATA;
				rd_r = S_AXI_RRESP;
				S_AXI_RREADY <= 1'b0;
			end
			stuck(n++);
			#1;
		end while (S_AXI_RREADY);
	endtask : rd

	task automatic rate(input logic [7:0] cfg, input logic [31:0] exp);
		logic [31:0] base;
		int n;
		n = 0;
		wr(`OFS_DIV_CFG, {24'h0, cfg});
		base = edges;
		while (edges - base < 32'h3) begin
			@(posedge CLK);
			stuck(n++);
		end
		chk(period, exp);
	endtask : rate

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic regs_scn();
		rd(`OFS_DIV_CFG);
		chk(rd_d, 32'h0);
		rd(`OFS_ROLE);
		chk(rd_d, 32'h0);
		rd(32'h0000_0040);
		chk({30'h0, rd_r}, {30'h0, `RESP_SLVERR});
		wr(32'h0000_0040, 32'h0000_0001);
		chk({30'h0, wr_b}, {30'h0, `RESP_SLVERR});
		wr(`OFS_DIV_CFG, 32'hFFFF_FFFF);
		chk({30'h0, wr_b}, {30'h0, `RESP_OKAY});
		rd(`OFS_DIV_CFG);
		chk(rd_d, 32'h77);
	endtask : regs_scn

	task automatic rates_scn();
		int n;
		n = 0;
		wr(`OFS_ROLE, 32'h1);
		chk({31'h0, MASTER_ACTIVE}, 32'h1);
		for (int i = 0; i < 8; i++)
			rate(8'(i << 4), 32'((i + 1) * 2));
		for (int i = 0; i < 8; i++)
			rate(8'(i), 32'(2 << i));
		rate(8'h35, 32'h100);
		rate(8'h77, 32'h800);
		rd(`OFS_STATUS);
		chk(rd_d & 32'h72, 32'h72);
		// Tick stands one cycle, just after the bit clock falls
		do begin
			@(posedge CLK);
			stuck(n++);
		end while (BIT_RATE_TICK !== 1'b1);
		chk({31'h0, BIT_CLK}, 32'h0);
		@(posedge CLK);
		chk({31'h0, BIT_RATE_TICK}, 32'h0);
	endtask : rates_scn

	task automatic slave_scn();
		wr(`OFS_ROLE, 32'h0);
		repeat (4) @(posedge CLK);
		for (int i = 0; i < 20; i++) begin
			@(posedge CLK);
			chk({31'h0, BIT_CLK}, 32'h0);
			chk({31'h0, BIT_RATE_TICK}, 32'h0);
			chk({31'h0, MASTER_ACTIVE}, 32'h0);
		end
	endtask : slave_scn

	initial begin
		CLK = 1'b0;
		RST_N = 1'b0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
		{S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
		{S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = 96'h0;
		S_AXI_WSTRB = 4'hF;
		error_cnt = 0;
		check_count = 0;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		regs_scn();
		rates_scn();
		slave_scn();
		report_and_stop();
	end
endmodule : testbench
